// ---- hw/mms_pkg.sv ----
package mms_pkg;

    // ----------------------------------------
    // Frame layout
    // ----------------------------------------
    localparam logic [5:0] PRE_LEN = 6'h20;        // Ones needed before a start
    localparam logic [31:0] PRE_BITS = 32'hffff_ffff;
    localparam logic [1:0] SOF_PAT = 2'h1;
    localparam logic [1:0] OP_RD = 2'h2;
    localparam logic [1:0] OP_WR = 2'h1;
    localparam logic [1:0] TA_WR = 2'h2;           // Master drives one then zero
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam logic [3:0] OP_LAST = 4'h1;
    localparam logic [3:0] ADDR_LAST = 4'h4;
    localparam logic [3:0] DATA_LAST = 4'hf;

    // Host bit positions within the 64-bit frame
    localparam int FRAME_W = 64;
    localparam logic [5:0] TA_FIRST = 6'h2e;
    localparam logic [5:0] DATA_FIRST = 6'h30;
    localparam logic [5:0] FRAME_LAST = 6'h3f;

    // ----------------------------------------
    // Register set per port
    // ----------------------------------------
    localparam int NUM_PORTS = 4;
    localparam int REGS_PER_PORT = 8;
    localparam logic [4:0] PHY_BASE_DEF = 5'h01;
    localparam logic [4:0] REG_LAST_STD = 5'h05;
    localparam logic [4:0] REG_EXT_A = 5'h1d;
    localparam logic [4:0] REG_EXT_B = 5'h1f;
    localparam logic [2:0] IDX_EXT_A = 3'h6;
    localparam logic [2:0] IDX_EXT_B = 3'h7;
    localparam logic [15:0] REG_RESET = 16'h0000;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int MDC_MIN_PERIOD_NS = 40;         // 25 MHz ceiling
    localparam int MDC_HALF_MIN = (MDC_MIN_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_STAGES = 2;

    // ----------------------------------------
    // State encodings
    // ----------------------------------------
    typedef enum logic [2:0] {
        L_PRE = 3'h0,
        L_SOF = 3'h1,
        L_OP = 3'h3,
        L_PHY = 3'h2,
        L_REG = 3'h6,
        L_TA = 3'h7,
        L_DAT = 3'h5
    } mms_lstate_type;

    typedef enum logic [0:0] {
        H_IDLE = 1'h0,
        H_RUN = 1'h1
    } mms_hstate_type;

endpackage : mms_pkg

// ---- hw/mms_if.sv ----
interface mms_if;
    logic mdc;
    logic m_mdio_o;
    logic m_mdio_oe;
    logic s_mdio_o;
    logic s_mdio_oe;
    logic mdio;

    // Wire level; an undriven line floats high through the pull-up
    assign mdio = m_mdio_oe ? m_mdio_o : (s_mdio_oe ? s_mdio_o : 1'h1);

    modport master (output mdc, output m_mdio_o, output m_mdio_oe, input mdio);
    modport slave (input mdc, input mdio, output s_mdio_o, output s_mdio_oe);
endinterface : mms_if

// ---- hw/mms_sync.sv ----
module mms_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    import mms_pkg::*;

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } mms_sync_type;

    mms_sync_type r;
    mms_sync_type next_r;

    // First stage feeds only the second
    always_comb begin
        next_r.s1 = d_i;
        next_r.s2 = r.s1;
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign q_o = r.s2;
endmodule : mms_sync

// ---- hw/mms_host.sv ----
module mms_host #(
    parameter int HALF = mms_pkg::MDC_HALF_MIN + 1
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    mms_if.master mif,
    input wire logic req_i,
    input wire logic req_write_i,
    input wire logic [mms_pkg::ADDR_W-1:0] req_phy_i,
    input wire logic [mms_pkg::ADDR_W-1:0] req_reg_i,
    input wire logic [mms_pkg::DATA_W-1:0] req_wdata_i,
    output logic busy_o,
    output logic done_o,
    output logic [mms_pkg::DATA_W-1:0] rdata_o
);
    import mms_pkg::*;

    localparam int PH_W = $clog2(HALF + 1);
    localparam logic [PH_W-1:0] PH_LAST = PH_W'(HALF - 1);

    typedef struct packed {
        mms_hstate_type st;
        logic [PH_W-1:0] ph;
        logic mdc;
        logic [5:0] bitn;
        logic [FRAME_W-1:0] frame;
        logic wr;
        logic oe;
        logic dout;
        logic [DATA_W-1:0] rd;
        logic busy;
        logic done;
    } mms_host_type;

    mms_host_type h;
    mms_host_type next_h;
    logic mdio_s;

    // ----------------------------------------
    // Pin input
    // ----------------------------------------
    mms_sync #(.W(1)) u_sync (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .d_i(mif.mdio),
        .q_o(mdio_s)
    );

    // ----------------------------------------
    // Frame sequencer
    // ----------------------------------------
    // Half period is one above the minimum so the synced read bit is settled at the rise
    always_comb begin
        next_h = h;
        next_h.done = 1'h0;
        case (h.st)
            H_IDLE: begin
                if (req_i) begin
                    next_h.frame = {PRE_BITS, SOF_PAT, req_write_i ? OP_WR : OP_RD, req_phy_i, req_reg_i,
                                    TA_WR, req_wdata_i};
                    next_h.dout = PRE_BITS[31];
                    next_h.oe = 1'h1;
                    next_h.bitn = '0;
                    next_h.ph = '0;
                    next_h.wr = req_write_i;
                    next_h.busy = 1'h1;
                    next_h.st = H_RUN;
                end
            end
            H_RUN: begin
                if (h.ph == PH_LAST) begin
                    next_h.ph = '0;
                    next_h.mdc = ~h.mdc;
                    if (!h.mdc) begin
                        // Rising edge: capture read data
                        if (h.bitn >= DATA_FIRST) begin
                            next_h.rd = {h.rd[DATA_W-2:0], mdio_s};
                        end
                    end else if (h.bitn == FRAME_LAST) begin
                        next_h.oe = 1'h0;
                        next_h.busy = 1'h0;
                        next_h.done = 1'h1;
                        next_h.st = H_IDLE;
                    end else begin
                        // Falling edge: present next bit
                        next_h.bitn = h.bitn + 6'h1;
                        next_h.frame = {h.frame[FRAME_W-2:0], 1'h0};
                        next_h.dout = h.frame[FRAME_W-2];
                        next_h.oe = h.wr || ((h.bitn + 6'h1) < TA_FIRST);
                    end
                end else begin
                    next_h.ph = h.ph + PH_W'(1);
                end
            end
            default: begin
                next_h.st = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            h <= '0;
        end else begin
            h <= next_h;
        end
    end

    assign mif.mdc = h.mdc;
    assign mif.m_mdio_o = h.dout;
    assign mif.m_mdio_oe = h.oe;
    assign busy_o = h.busy;
    assign done_o = h.done;
    assign rdata_o = h.rd;
endmodule : mms_host

// ---- hw/mms_device.sv ----
// Overview of operation
// - Master sends 32 ones before each frame
// - Decode only after 32 consecutive ones
// - Start pattern zero then one
// - Opcode 10 reads, 01 writes
// - Five-bit PHY address, MSB first
// - Five-bit register address, MSB first
// - Nobody drives first read turnaround bit
// - Slave drives zero, then read data
// - Master drives one, zero on write turnaround
// - Sixteen data bits, bit 15 first
// - Management clock at most 25 MHz
// - Registers 0-5, 1d, 1f per port
// - No switch registers reachable here
// - Release line after last read bit
// - Four PHY register sets by address
module mms_device #(
    parameter logic [4:0] PHY_BASE = mms_pkg::PHY_BASE_DEF
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    mms_if.slave mif,
    output logic wr_stb_o,
    output logic [mms_pkg::ADDR_W-1:0] wr_phy_o,
    output logic [mms_pkg::ADDR_W-1:0] wr_reg_o,
    output logic [mms_pkg::DATA_W-1:0] wr_data_o
);
    import mms_pkg::*;

    localparam int PORT_W = $clog2(NUM_PORTS);
    localparam int IDX_W = $clog2(REGS_PER_PORT);

    typedef logic [NUM_PORTS-1:0][REGS_PER_PORT-1:0][DATA_W-1:0] mms_bank_type;

    // Link side state, clocked by the management clock
    typedef struct packed {
        mms_lstate_type st;
        logic [5:0] ones;
        logic [3:0] cnt;
        logic [1:0] op;
        logic [ADDR_W-1:0] phy;
        logic [ADDR_W-1:0] regad;
        logic hit;
        logic [DATA_W-1:0] sr;
        logic oe;
        logic dout;
        logic tog;
        logic [ADDR_W-1:0] wphy;
        logic [ADDR_W-1:0] wreg;
        logic [DATA_W-1:0] wdata;
        mms_bank_type bank;
    } mms_lnk_type;

    // User side state, clocked by clk_i
    typedef struct packed {
        logic tog_d;
        logic stb;
        logic [ADDR_W-1:0] phy;
        logic [ADDR_W-1:0] regad;
        logic [DATA_W-1:0] data;
    } mms_usr_type;

    mms_lnk_type l;
    mms_lnk_type next_l;
    mms_usr_type u;
    mms_usr_type next_u;
    logic tog_s;
    logic [ADDR_W-1:0] port_off;
    logic reg_ok;
    logic [IDX_W-1:0] reg_idx;
    logic [PORT_W-1:0] port_idx;
    logic [DATA_W-1:0] rd_word;
    logic [DATA_W-1:0] wr_word;

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    // Only the six standard registers and the two extended ones map; anything else is a hole
    always_comb begin
        reg_ok = 1'h1;
        reg_idx = '0;
        if (l.regad <= REG_LAST_STD) begin
            reg_idx = l.regad[IDX_W-1:0];
        end else if (l.regad == REG_EXT_A) begin
            reg_idx = IDX_EXT_A;
        end else if (l.regad == REG_EXT_B) begin
            reg_idx = IDX_EXT_B;
        end else begin
            reg_ok = 1'h0;
        end
    end

    // Port window starts at PHY_BASE, wraps below it to large offsets
    assign port_off = l.phy - PHY_BASE;
    assign port_idx = port_off[PORT_W-1:0];
    assign rd_word = reg_ok ? l.bank[port_idx][reg_idx] : REG_RESET;
    assign wr_word = {l.sr[DATA_W-2:0], mif.mdio};

    // ----------------------------------------
    // Frame decoder
    // ----------------------------------------
    // Each frame must be preceded by its own preamble; the count restarts after every frame
    always_comb begin
        next_l = l;
        case (l.st)
            L_PRE: begin
                if (mif.mdio) begin
                    if (l.ones != PRE_LEN) begin
                        next_l.ones = l.ones + 6'h1;
                    end
                end else begin
                    // A zero after a full preamble is the first start bit
                    if (l.ones == PRE_LEN) begin
                        next_l.st = L_SOF;
                    end
                    next_l.ones = '0;
                end
            end
            L_SOF: begin
                next_l.cnt = '0;
                next_l.st = mif.mdio ? L_OP : L_PRE;
            end
            L_OP: begin
                next_l.op = {l.op[0], mif.mdio};
                next_l.cnt = l.cnt + 4'h1;
                if (l.cnt == OP_LAST) begin
                    next_l.cnt = '0;
                    if (({l.op[0], mif.mdio} == OP_RD) || ({l.op[0], mif.mdio} == OP_WR)) begin
                        next_l.st = L_PHY;
                    end else begin
                        next_l.st = L_PRE;
                    end
                end
            end
            L_PHY: begin
                next_l.phy = {l.phy[ADDR_W-2:0], mif.mdio};
                next_l.cnt = l.cnt + 4'h1;
                if (l.cnt == ADDR_LAST) begin
                    next_l.cnt = '0;
                    next_l.st = L_REG;
                end
            end
            L_REG: begin
                next_l.regad = {l.regad[ADDR_W-2:0], mif.mdio};
                next_l.cnt = l.cnt + 4'h1;
                if (l.cnt == ADDR_LAST) begin
                    next_l.cnt = '0;
                    next_l.hit = (port_off < ADDR_W'(NUM_PORTS));
                    next_l.st = L_TA;
                end
            end
            L_TA: begin
                if (l.cnt == '0) begin
                    // First turnaround bit stays released; zero goes out for the second
                    next_l.cnt = 4'h1;
                    if ((l.op == OP_RD) && l.hit) begin
                        next_l.oe = 1'h1;
                        next_l.dout = 1'h0;
                    end
                end else begin
                    // Write turnaround bits from the master are not checked
                    next_l.cnt = '0;
                    next_l.st = L_DAT;
                    next_l.sr = ((l.op == OP_RD) && l.hit) ? rd_word : REG_RESET;
                    next_l.dout = rd_word[DATA_W-1];
                end
            end
            L_DAT: begin
                // One shifter serves both directions: out from the top, in at the bottom
                next_l.sr = wr_word;
                next_l.dout = l.sr[DATA_W-2];
                next_l.cnt = l.cnt + 4'h1;
                if (l.cnt == DATA_LAST) begin
                    next_l.oe = 1'h0;
                    next_l.cnt = '0;
                    next_l.st = L_PRE;
                    if ((l.op == OP_WR) && l.hit && reg_ok) begin
                        next_l.bank[port_idx][reg_idx] = wr_word;
                        next_l.wphy = l.phy;
                        next_l.wreg = l.regad;
                        next_l.wdata = wr_word;
                        next_l.tog = ~l.tog;
                    end
                end
            end
            default: begin
                next_l.st = L_PRE;
                next_l.oe = 1'h0;
            end
        endcase
    end

    // Link clock may stop between frames; reset is asynchronous so it still takes hold
    always_ff @(posedge mif.mdc or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            l <= '0;
        end else begin
            l <= next_l;
        end
    end

    assign mif.s_mdio_o = l.dout;
    assign mif.s_mdio_oe = l.oe;

    // ----------------------------------------
    // Write notice crossing
    // ----------------------------------------
    mms_sync #(.W(1)) u_tog_sync (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .d_i(l.tog),
        .q_o(tog_s)
    );

    // Held words are stable long before the toggle arrives; next write is a frame away
    always_comb begin
        next_u = u;
        next_u.tog_d = tog_s;
        next_u.stb = (tog_s != u.tog_d);
        if (tog_s != u.tog_d) begin
            next_u.phy = l.wphy;
            next_u.regad = l.wreg;
            next_u.data = l.wdata;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            u <= '0;
        end else begin
            u <= next_u;
        end
    end

    assign wr_stb_o = u.stb;
    assign wr_phy_o = u.phy;
    assign wr_reg_o = u.regad;
    assign wr_data_o = u.data;
endmodule : mms_device

// ---- dv/mms_asserts.sv ----
module mms_asserts #(
    parameter logic [4:0] PHY_BASE = mms_pkg::PHY_BASE_DEF
) (
    input wire logic sys_rst_i,
    input wire logic mdc,
    input wire logic m_mdio_oe,
    input wire logic s_mdio_oe,
    input wire logic mdio
);
    timeunit 1ns;
    timeprecision 100ps;
    import mms_pkg::*;

    // ----------------------------------------
    // Frame tracker
    // ----------------------------------------
    logic [5:0] ones;
    logic [5:0] pos;
    logic [13:0] hdr;
    logic rd;
    logic hit;

    // Own decoder of the wire, so a device slip cannot hide itself
    always_ff @(posedge mdc or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ones <= 6'h00;
            pos <= 6'h00;
            hdr <= 14'h0000;
        end else if (pos != 6'h00) begin
            pos <= {1'b0, pos[4:0] + 5'h01};
            ones <= 6'h00;
            if (pos < 6'h0e) begin
                hdr <= {hdr[12:0], mdio};
            end
        end else if (ones == PRE_LEN && !mdio) begin
            pos <= 6'h01;
            hdr <= {hdr[12:0], mdio};
        end else begin
            ones <= mdio ? ones + {5'h00, ones != PRE_LEN} : 6'h00;
        end
    end

    // Header fields, valid once pos is past the register address
    assign rd = hdr[11:10] == OP_RD;
    assign hit = (hdr[9:5] - PHY_BASE) < 5'h04;

    default clocking cb @(posedge mdc);
    endclocking
    default disable iff (sys_rst_i);

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_preamble;
        pos == 6'h00 && ones != PRE_LEN && m_mdio_oe |-> mdio;
    endproperty
    a_preamble: assert property (p_preamble) else $error("short preamble");
    property p_quiet_head;
        pos < 6'h0f |-> !s_mdio_oe;
    endproperty
    a_quiet_head: assert property (p_quiet_head) else $error("device drove early");
    property p_ta_float;
        pos == 6'h0e && rd |-> !s_mdio_oe && !m_mdio_oe && mdio;
    endproperty
    a_ta_float: assert property (p_ta_float) else $error("first turnaround driven");
    property p_ta_zero;
        pos == 6'h0f && rd && hit |-> s_mdio_oe && !mdio;
    endproperty
    a_ta_zero: assert property (p_ta_zero) else $error("second turnaround not zero");
    property p_read_drive;
        pos > 6'h0f && rd && hit |-> s_mdio_oe && !m_mdio_oe;
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("read data not driven");
    property p_release;
        pos == 6'h1f && rd && hit |=> !s_mdio_oe;
    endproperty
    a_release: assert property (p_release) else $error("line kept after read");
    property p_port_decode;
        pos == 6'h0f && rd |-> s_mdio_oe == hit;
    endproperty
    a_port_decode: assert property (p_port_decode) else $error("port decode wrong");
    property p_foreign;
        pos > 6'h0d && !hit |-> !s_mdio_oe;
    endproperty
    a_foreign: assert property (p_foreign) else $error("foreign address answered");
    property p_write_quiet;
        pos > 6'h0d && hdr[11:10] == OP_WR |-> !s_mdio_oe && m_mdio_oe;
    endproperty
    a_write_quiet: assert property (p_write_quiet) else $error("write frame contended");

    // Main scenarios reached
    c_read: cover property (pos == 6'h1f && rd && hit);
    c_write: cover property (pos == 6'h1f && !rd && hit);
    c_foreign: cover property (pos == 6'h1f && !hit);
endmodule : mms_asserts

// ---- dv/tb_mdio_management_slave.sv ----
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_errors++; \
    $display("wrong value at %0t: got %h exp %h", $time, (got), (exp)); end end

module tb_mdio_management_slave;
    timeunit 1ns;
    timeprecision 100ps;
    import mms_pkg::*;

    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b0;
    logic req_i = 1'b0;
    logic req_write_i = 1'b0;
    logic [4:0] req_phy_i = 5'h00;
    logic [4:0] req_reg_i = 5'h00;
    logic [15:0] req_wdata_i = 16'h0000;
    logic busy_o;
    logic done_o;
    logic [15:0] rdata_o;
    logic wr_stb_o;
    logic [4:0] wr_phy_o;
    logic [4:0] wr_reg_o;
    logic [15:0] wr_data_o;
    logic seen;
    int n_errors = 0;
    int n_checks = 0;
    logic [15:0] lfsr = 16'h80a2;
    logic [15:0] bank [4][8];
    logic [4:0] regs [8] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, REG_LAST_STD, REG_EXT_A, REG_EXT_B};
    logic [16:0] q_rd [$];
    logic [25:0] q_wr [$];
    logic [16:0] exp_rd;
    logic [25:0] exp_wr;

    mms_if link();
    mms_if bad();

    mms_host mms_host_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .mif(link), .req_i(req_i),
        .req_write_i(req_write_i), .req_phy_i(req_phy_i), .req_reg_i(req_reg_i),
        .req_wdata_i(req_wdata_i), .busy_o(busy_o), .done_o(done_o), .rdata_o(rdata_o));
    mms_device #(.PHY_BASE(PHY_BASE_DEF)) mms_device_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .mif(link), .wr_stb_o(wr_stb_o), .wr_phy_o(wr_phy_o), .wr_reg_o(wr_reg_o), .wr_data_o(wr_data_o));
    // Second device faces a rule-breaking driver of the bench
    mms_device #(.PHY_BASE(PHY_BASE_DEF)) mms_device_inst_b (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .mif(bad), .wr_stb_o(), .wr_phy_o(), .wr_reg_o(), .wr_data_o());
    mms_asserts #(.PHY_BASE(PHY_BASE_DEF)) mms_asserts_inst (.sys_rst_i(sys_rst_i), .mdc(link.mdc),
        .m_mdio_oe(link.m_mdio_oe), .s_mdio_oe(link.s_mdio_oe), .mdio(link.mdio));

    initial begin
        forever #10 clk_i = ~clk_i;
    end

    // ----------------------------------------
    // Stimulus helpers
    // ----------------------------------------
    function automatic logic [15:0] next_rand(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : next_rand

    // One host transfer; notes the expected outcome first
    task automatic op(input logic wr, input logic [4:0] phy, input logic [4:0] rg, input logic [15:0] d);
        logic [4:0] port;
        int idx;
        port = phy - PHY_BASE_DEF;
        idx = -1;
        for (int k = 0; k < 8; k++) begin
            if (regs[k] === rg) idx = k;
        end
        // Writes to holes in the map are dropped and raise no strobe
        if (wr && port < 5'h04 && idx >= 0) begin
            bank[port[1:0]][idx] = d;
            q_wr.push_back({phy, rg, d});
        end
        // Foreign read floats on the pull-up; holes read zero
        q_rd.push_back({!wr, port > 5'h03 ? 16'hffff : (idx < 0 ? 16'h0000 : bank[port[1:0]][idx])});
        req_i = 1'b1;
        req_write_i = wr;
        req_phy_i = phy;
        req_reg_i = rg;
        req_wdata_i = d;
        @(posedge clk_i);
        #1;
        req_i = 1'b0;
        for (int t = 0; t < 400; t++) begin
            @(posedge clk_i);
            #1;
            if (done_o === 1'b1) break;
            if (t == 20) `CHK(busy_o, 1'b1)
            req_i = (t == 20); // Stray request while busy must be ignored
        end
    endtask : op

    // Raw frame with a chosen opcode and preamble length at the 15 ns link clock
    task automatic raw_frame(input int n_ones, input logic [1:0] opc, output logic hit);
        logic [31:0] f;
        f = {SOF_PAT, opc, PHY_BASE_DEF, 5'h00, 2'h3, 16'hffff};
        hit = 1'b0;
        for (int i = 0; i < n_ones + 32; i++) begin
            bad.m_mdio_oe = (i < n_ones + 14);
            bad.m_mdio_o = (i < n_ones) ? 1'b1 : f[31 - (i - n_ones)];
            #3.5 bad.mdc = 1'b1;
            #7.5 hit = hit | (bad.s_mdio_oe === 1'b1);
            bad.mdc = 1'b0;
            #4;
        end
    endtask : raw_frame

    // ----------------------------------------
    // Scoreboard
    // ----------------------------------------
    always @(posedge clk_i) begin
        if (done_o === 1'b1) begin
            `CHK(busy_o, 1'b0)
            if (q_rd.size() == 0) `CHK(1'b0, 1'b1)
            else begin
                exp_rd = q_rd.pop_front();
                if (exp_rd[16]) `CHK(rdata_o, exp_rd[15:0])
            end
        end
        if (wr_stb_o === 1'b1) begin
            if (q_wr.size() == 0) `CHK(1'b0, 1'b1)
            else begin
                exp_wr = q_wr.pop_front();
                `CHK({wr_phy_o, wr_reg_o, wr_data_o}, exp_wr)
            end
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        for (int p = 0; p < 4; p++) begin
            for (int k = 0; k < 8; k++) bank[p][k] = REG_RESET;
        end
        bad.mdc = 1'b0;
        bad.m_mdio_o = 1'b1;
        bad.m_mdio_oe = 1'b0;
        #1;
        sys_rst_i = 1'b1; // Real rising edge, so link logic resets with its clock stopped
        repeat (20) @(posedge clk_i);
        #1;
        sys_rst_i = 1'b0;
        // Reset values, then holes in the map
        op(1'b0, 5'h01, 5'h00, 16'h0000);
        op(1'b0, 5'h04, REG_EXT_B, 16'h0000);
        op(1'b1, 5'h02, 5'h06, 16'h1234);
        op(1'b0, 5'h02, 5'h06, 16'h0000);
        op(1'b0, 5'h03, 5'h1e, 16'h0000);
        // Random fill of every port and register, back to back, then read back
        for (int i = 0; i < 64; i++) begin
            lfsr = next_rand(lfsr);
            op(i < 32, PHY_BASE_DEF + 5'(i[4:3]), regs[i[2:0]], lfsr);
        end
        // Foreign addresses must neither answer nor alias onto a port
        op(1'b1, 5'h05, 5'h00, 16'h5a5a);
        op(1'b1, 5'h00, 5'h00, 16'ha5a5);
        op(1'b0, 5'h05, 5'h00, 16'h0000);
        op(1'b0, 5'h1f, 5'h01, 16'h0000);
        op(1'b0, 5'h01, 5'h00, 16'h0000);
        op(1'b0, 5'h04, 5'h00, 16'h0000);
        // Short preamble and unknown opcode ignored, a full read answered
        raw_frame(31, OP_RD, seen);
        `CHK(seen, 1'b0)
        raw_frame(32, 2'h3, seen);
        `CHK(seen, 1'b0)
        raw_frame(32, OP_RD, seen);
        `CHK(seen, 1'b1)
        repeat (10) @(posedge clk_i);
        `CHK(q_rd.size() + q_wr.size(), 0)
        results();
    end

    // Hang guard, well beyond the expected run length
    initial begin
        #800000;
        n_errors++;
        results();
    end

    task automatic results;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results
endmodule : tb_mdio_management_slave
